// file: ilrf_top.sv
// ilrf_top.sv: input loop feedback, receiver mode and reference selection configuration.
// assumes: register writes arrive as a one-cycle strobe from the serial control port
// logic on REF_CLK; the reference select pin and clock fail flag are asynchronous.
//
// What this block does
// - zero delay mode applies only with feedback bit 0
// - internal zero delay: receiver off, channel 0 path
// - external zero delay: receiver on, external feedback
// - feedback bit 1 uses oscillator input receiver
// - zero delay receiver differential or single-ended
// - zero delay pin select only when single-ended
// - reference B pin select only when single-ended
// - reference A pin select only when single-ended
// - reference B divider own or reference A's
// - clock fail: control voltage forced mid-supply or tracks pump
// - three-bit selection mode field, reset 000
// - top bit 0: decode lower two bits
// - top bit 1: external pin chooses reference
`timescale 1ns/1ps
`default_nettype none
`include "ilrf_cfg.svh"

module ilrf_top (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic REG_WE,
	input wire logic [`ILRF_ADDR_W-1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic REF_SEL_PIN,
	input wire logic CLOCK_FAIL,
	output ilrf_pkg::ilrf_fb_t FEEDBACK_SOURCE,
	output ilrf_pkg::ilrf_rcv_t ZERO_DELAY_RCV,
	output ilrf_pkg::ilrf_rcv_t REFERENCE_A_RCV,
	output ilrf_pkg::ilrf_rcv_t REFERENCE_B_RCV,
	output logic OSCILLATOR_INPUT_FB_EN,
	output logic [9:0] REFERENCE_B_RDIV,
	output logic VCTRL_FORCE_MID,
	output logic VCTRL_TRACK_PUMP,
	output ilrf_pkg::ilrf_refmode_t REF_MODE,
	output logic REF_USE_B
);

	logic [7:0] rcv_fb_r;
	logic [7:0] misc_r;
	logic [7:0] rcv_ctl_r;
	logic [7:0] rdiv_a_lo_r;
	logic [7:0] rdiv_a_hi_r;
	logic [7:0] rdiv_b_lo_r;
	logic [7:0] rdiv_b_hi_r;
	logic sel_meta_r;
	logic sel_sync_r;
	logic fail_meta_r;
	logic fail_sync_r;
	logic zd_active;
	logic zd_internal;
	ilrf_pkg::ilrf_refmode_t mode_nxt;

	// register writes; reserved bits are masked to read zero, except in the receiver control register, which is stored whole
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rcv_fb_r <= `ILRF_RST_RCV_FB;
			misc_r <= `ILRF_RST_MISC;
			rcv_ctl_r <= `ILRF_RST_RCV_CTL;
			rdiv_a_lo_r <= `ILRF_RST_RDIV;
			rdiv_a_hi_r <= `ILRF_RST_RDIV;
			rdiv_b_lo_r <= `ILRF_RST_RDIV;
			rdiv_b_hi_r <= `ILRF_RST_RDIV;
		end else if (REG_WE) begin
			if (REG_ADDR == `ILRF_ADDR_RCV_FB) begin
				rcv_fb_r <= REG_WDATA & `ILRF_RCV_FB_WMASK;
			end else if (REG_ADDR == `ILRF_ADDR_MISC) begin
				misc_r <= REG_WDATA & `ILRF_MISC_WMASK;
			end else if (REG_ADDR == `ILRF_ADDR_RCV_CTL) begin
				rcv_ctl_r <= REG_WDATA;
			end else if (REG_ADDR == `ILRF_ADDR_RDIV_A_LO) begin
				rdiv_a_lo_r <= REG_WDATA;
			end else if (REG_ADDR == `ILRF_ADDR_RDIV_A_HI) begin
				rdiv_a_hi_r <= {6'h00, REG_WDATA[1:0]};
			end else if (REG_ADDR == `ILRF_ADDR_RDIV_B_LO) begin
				rdiv_b_lo_r <= REG_WDATA;
			end else if (REG_ADDR == `ILRF_ADDR_RDIV_B_HI) begin
				rdiv_b_hi_r <= {6'h00, REG_WDATA[1:0]};
			end
		end
	end

	// read mux; unmapped addresses return zero
	always_comb begin
		if (REG_ADDR == `ILRF_ADDR_RCV_FB) begin
			REG_RDATA = rcv_fb_r;
		end else if (REG_ADDR == `ILRF_ADDR_MISC) begin
			REG_RDATA = misc_r;
		end else if (REG_ADDR == `ILRF_ADDR_RCV_CTL) begin
			REG_RDATA = rcv_ctl_r;
		end else if (REG_ADDR == `ILRF_ADDR_RDIV_A_LO) begin
			REG_RDATA = rdiv_a_lo_r;
		end else if (REG_ADDR == `ILRF_ADDR_RDIV_A_HI) begin
			REG_RDATA = rdiv_a_hi_r;
		end else if (REG_ADDR == `ILRF_ADDR_RDIV_B_LO) begin
			REG_RDATA = rdiv_b_lo_r;
		end else if (REG_ADDR == `ILRF_ADDR_RDIV_B_HI) begin
			REG_RDATA = rdiv_b_hi_r;
		end else begin
			REG_RDATA = 8'h00;
		end
	end

	// two-flop synchronisers for the asynchronous pin and fail flag
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sel_meta_r <= 1'b0;
			sel_sync_r <= 1'b0;
			fail_meta_r <= 1'b0;
			fail_sync_r <= 1'b0;
		end else begin
			sel_meta_r <= REF_SEL_PIN;
			sel_sync_r <= sel_meta_r;
			fail_meta_r <= CLOCK_FAIL;
			fail_sync_r <= fail_meta_r;
		end
	end

	// zero delay mode bit is only meaningful while feedback bit is 0
	assign zd_active = ~rcv_fb_r[`ILRF_B_FB_OSC];
	assign zd_internal = zd_active & rcv_fb_r[`ILRF_B_ZD_MODE];

	// feedback source selection
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			FEEDBACK_SOURCE <= ilrf_pkg::ILRF_FB_ZD_EXT;
			OSCILLATOR_INPUT_FB_EN <= 1'b0;
		end else begin
			OSCILLATOR_INPUT_FB_EN <= ~zd_active;
			if (!zd_active) begin
				FEEDBACK_SOURCE <= ilrf_pkg::ILRF_FB_OSC;
			end else if (zd_internal) begin
				FEEDBACK_SOURCE <= ilrf_pkg::ILRF_FB_ZD_INT;
			end else begin
				FEEDBACK_SOURCE <= ilrf_pkg::ILRF_FB_ZD_EXT;
			end
		end
	end

	// zero delay receiver: on only for external zero delay feedback
	ilrf_rcv_cfg u_zd_rcv (
		.clk(REF_CLK),
		.rst(RST),
		.en(zd_active & ~zd_internal),
		.diff(rcv_fb_r[`ILRF_B_ZD_DIFF]),
		.se_sel(rcv_fb_r[`ILRF_B_ZD_SE_SEL]),
		.cfg(ZERO_DELAY_RCV)
	);

	// reference A receiver; differential bit from the receiver control register, pin select from the feedback register
	ilrf_rcv_cfg u_ref_a_rcv (
		.clk(REF_CLK),
		.rst(RST),
		.en(1'b1),
		.diff(rcv_ctl_r[`ILRF_B_REF_A_DIFF]),
		.se_sel(rcv_fb_r[`ILRF_B_REF_A_SE_SEL]),
		.cfg(REFERENCE_A_RCV)
	);

	// reference B receiver
	ilrf_rcv_cfg u_ref_b_rcv (
		.clk(REF_CLK),
		.rst(RST),
		.en(1'b1),
		.diff(rcv_ctl_r[`ILRF_B_REF_B_DIFF]),
		.se_sel(rcv_fb_r[`ILRF_B_REF_B_SE_SEL]),
		.cfg(REFERENCE_B_RCV)
	);

	// reference B divider; sharing A's ratio is only safe at equal frequencies
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			REFERENCE_B_RDIV <= 10'h000;
		end else if (misc_r[`ILRF_B_REF_B_INDEP]) begin
			REFERENCE_B_RDIV <= {rdiv_b_hi_r[1:0], rdiv_b_lo_r};
		end else begin
			REFERENCE_B_RDIV <= {rdiv_a_hi_r[1:0], rdiv_a_lo_r};
		end
	end

	// control voltage behaviour on clock failure
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			VCTRL_FORCE_MID <= 1'b0;
			VCTRL_TRACK_PUMP <= 1'b0;
		end else begin
			VCTRL_FORCE_MID <= fail_sync_r & misc_r[`ILRF_B_VCTRL_MID];
			VCTRL_TRACK_PUMP <= fail_sync_r & ~misc_r[`ILRF_B_VCTRL_MID];
		end
	end

	// reference selection mode decode
	always_comb begin
		if (misc_r[`ILRF_F_REFSEL_HI]) begin
			mode_nxt = sel_sync_r ? ilrf_pkg::ILRF_SEL_PIN_B : ilrf_pkg::ILRF_SEL_PIN_A;
		end else begin
			case (misc_r[`ILRF_F_REFSEL_HI-1:`ILRF_F_REFSEL_LO])
				2'b00: mode_nxt = ilrf_pkg::ILRF_SEL_NONREVERT_B;
				2'b01: mode_nxt = ilrf_pkg::ILRF_SEL_REVERT_A;
				2'b10: mode_nxt = ilrf_pkg::ILRF_SEL_FORCE_A;
				default: mode_nxt = ilrf_pkg::ILRF_SEL_FORCE_B;
			endcase
		end
	end

	// registered mode and preferred reference
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			REF_MODE <= ilrf_pkg::ILRF_SEL_NONREVERT_B;
			REF_USE_B <= 1'b1;
		end else begin
			REF_MODE <= mode_nxt;
			REF_USE_B <= (mode_nxt == ilrf_pkg::ILRF_SEL_NONREVERT_B) ||
				(mode_nxt == ilrf_pkg::ILRF_SEL_FORCE_B) ||
				(mode_nxt == ilrf_pkg::ILRF_SEL_PIN_B);
		end
	end

endmodule : ilrf_top
`default_nettype wire

// file: ilrf_cfg.svh
// ilrf_cfg.svh: offsets, field positions, reset values and widths of the input loop
// feedback and reference configuration block.
// assumes: included by bare name from the package and the design modules.
`ifndef ILRF_CFG_SVH
`define ILRF_CFG_SVH

`define ILRF_ADDR_W 10
`define ILRF_ADDR_RCV_FB 10'h01B
`define ILRF_ADDR_MISC 10'h01C
`define ILRF_ADDR_RCV_CTL 10'h01A
`define ILRF_ADDR_RDIV_A_LO 10'h010
`define ILRF_ADDR_RDIV_A_HI 10'h011
`define ILRF_ADDR_RDIV_B_LO 10'h012
`define ILRF_ADDR_RDIV_B_HI 10'h013

`define ILRF_RST_RCV_FB 8'h00
`define ILRF_RST_MISC 8'h00
`define ILRF_RST_RCV_CTL 8'h00
`define ILRF_RST_RDIV 8'h00

// receiver/feedback register fields
`define ILRF_B_ZD_MODE 5
`define ILRF_B_FB_OSC 4
`define ILRF_B_ZD_SE_SEL 3
`define ILRF_B_ZD_DIFF 2
`define ILRF_B_REF_B_SE_SEL 1
`define ILRF_B_REF_A_SE_SEL 0
`define ILRF_RCV_FB_WMASK 8'h3F

// misc control fields
`define ILRF_B_REF_B_INDEP 7
`define ILRF_B_VCTRL_MID 6
`define ILRF_F_REFSEL_HI 4
`define ILRF_F_REFSEL_LO 2
`define ILRF_MISC_WMASK 8'hDC

// neighbouring receiver control fields
`define ILRF_B_REF_B_DIFF 6
`define ILRF_B_REF_A_DIFF 5

`endif

// file: ilrf_pkg.sv
// ilrf_pkg.sv: types shared by the input loop configuration block.
// assumes: ilrf_cfg.svh is on the include path.
`include "ilrf_cfg.svh"

package ilrf_pkg;

	// feedback path chosen for the input loop
	typedef enum logic [1:0] {
		ILRF_FB_OSC = 2'b00,
		ILRF_FB_ZD_EXT = 2'b01,
		ILRF_FB_ZD_INT = 2'b10
	} ilrf_fb_t;

	// reference selection behaviour
	typedef enum logic [2:0] {
		ILRF_SEL_NONREVERT_B = 3'b000,
		ILRF_SEL_REVERT_A = 3'b001,
		ILRF_SEL_FORCE_A = 3'b010,
		ILRF_SEL_FORCE_B = 3'b011,
		ILRF_SEL_PIN_A = 3'b100,
		ILRF_SEL_PIN_B = 3'b101
	} ilrf_refmode_t;

	// one receiver setting
	typedef struct packed {
		logic enable;
		logic differential;
		logic pin_select;
	} ilrf_rcv_t;

	// register write strobe
	typedef struct packed {
		logic we;
		logic [`ILRF_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} ilrf_wr_t;

endpackage : ilrf_pkg

// file: ilrf_rcv_cfg.sv
// ilrf_rcv_cfg.sv: one input receiver's mode decode.
// assumes: driven from registered control bits on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ilrf_cfg.svh"

module ilrf_rcv_cfg (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic diff,
	input wire logic se_sel,
	output var ilrf_pkg::ilrf_rcv_t cfg
);

	// pin select matters only single-ended; registered so the output comes from a flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= '0;
		end else begin
			cfg.enable <= en;
			cfg.differential <= en & diff;
			cfg.pin_select <= en & ~diff & se_sel;
		end
	end

endmodule : ilrf_rcv_cfg
`default_nettype wire

// file: ilrf_top_properties.sv
// ilrf_top_properties.sv: port checker for ilrf_top
// assumes: bound to ilrf_top by the testbench, all on REF_CLK
`timescale 1ns/1ps
`default_nettype none
`include "ilrf_cfg.svh"
module ilrf_props (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic REG_WE,
	input wire logic [`ILRF_ADDR_W-1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire ilrf_pkg::ilrf_fb_t FEEDBACK_SOURCE,
	input wire ilrf_pkg::ilrf_rcv_t ZERO_DELAY_RCV,
	input wire ilrf_pkg::ilrf_rcv_t REFERENCE_A_RCV,
	input wire ilrf_pkg::ilrf_rcv_t REFERENCE_B_RCV,
	input wire logic OSCILLATOR_INPUT_FB_EN,
	input wire logic VCTRL_FORCE_MID,
	input wire logic VCTRL_TRACK_PUMP,
	input wire ilrf_pkg::ilrf_refmode_t REF_MODE,
	input wire logic REF_USE_B
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// write decode; derived outputs land two edges after the write edge
	logic wfb, wmc;
	logic [1:0] low2;
	assign wfb = REG_WE && REG_ADDR == `ILRF_ADDR_RCV_FB;
	assign wmc = REG_WE && REG_ADDR == `ILRF_ADDR_MISC;
	assign low2 = REG_WDATA[3:2];
	fb_osc_a: assert property (
		wfb && REG_WDATA[4] |=> ##1 FEEDBACK_SOURCE == ilrf_pkg::ILRF_FB_OSC
		&& OSCILLATOR_INPUT_FB_EN && !ZERO_DELAY_RCV.enable) else $error("osc feedback wrong");
	zd_int_a: assert property (
		wfb && REG_WDATA[5:4] == 2'h2 |=> ##1 FEEDBACK_SOURCE == ilrf_pkg::ILRF_FB_ZD_INT
		&& !ZERO_DELAY_RCV.enable) else $error("internal zero delay wrong");
	zd_ext_a: assert property (
		wfb && REG_WDATA[5:4] == 2'h0 |=> ##1 FEEDBACK_SOURCE == ilrf_pkg::ILRF_FB_ZD_EXT
		&& ZERO_DELAY_RCV.enable && !OSCILLATOR_INPUT_FB_EN) else $error("external zero delay wrong");
	// a powered-down zero delay receiver reports no mode, so only the enabled case is held
	zd_diff_a: assert property (
		wfb && REG_WDATA[5:4] == 2'h0 && REG_WDATA[2] |=> ##1 ZERO_DELAY_RCV.differential)
		else $error("zero delay diff wrong");
	zd_pin_a: assert property (
		wfb && REG_WDATA[5:4] == 2'h0 |=> ##1
		ZERO_DELAY_RCV.pin_select == ($past(REG_WDATA[3:2], 2) == 2'h2))
		else $error("zero delay pin wrong");
	ref_a_pin_a: assert property (
		REFERENCE_A_RCV.differential |-> !REFERENCE_A_RCV.pin_select) else $error("ref a pin used");
	ref_b_pin_a: assert property (
		REFERENCE_B_RCV.differential |-> !REFERENCE_B_RCV.pin_select) else $error("ref b pin used");
	vctrl_excl_a: assert property (
		!(VCTRL_FORCE_MID && VCTRL_TRACK_PUMP)) else $error("control voltage both ways");
	use_b_a: assert property (
		REF_USE_B == (REF_MODE inside {3'h0, 3'h3, 3'h5})) else $error("reference use wrong");
	mode_dec_a: assert property (
		wmc && !REG_WDATA[4] |=> ##1 REF_MODE == {1'b0, $past(low2, 2)}) else $error("mode decode wrong");
	pin_mode_a: assert property (
		wmc && REG_WDATA[4] |=> ##1 REF_MODE[2:1] == 2'h2) else $error("pin mode wrong");
	cover property (wfb && REG_WDATA[5:4] == 2'h2);
	cover property (VCTRL_FORCE_MID);
	cover property (REF_MODE == ilrf_pkg::ILRF_SEL_PIN_B);
endmodule : ilrf_props
`default_nettype wire

// file: ilrf_top_test.sv
// ilrf_top_test.sv: self-checking bench for ilrf_top, checker bound at foot
// assumes: package, design and ilrf_top_properties.sv compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ilrf_cfg.svh"
module ilrf_top_test;
	logic clk = 0, rst = 1, we = 0, pin = 0, fail = 0, oen, fmid, trk, useb;
	logic [9:0] addr = 0, rdiv;
	logic [7:0] wd = 0, rdata, d, e;
	ilrf_pkg::ilrf_fb_t fb;
	ilrf_pkg::ilrf_rcv_t zd, ra, rb;
	ilrf_pkg::ilrf_refmode_t mode;
	int failures = 0, check_count = 0, cyc = 0;
	initial forever #2.5 clk = ~clk;
	ilrf_top dut (.REF_CLK(clk), .RST(rst), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wd),
		.REG_RDATA(rdata), .REF_SEL_PIN(pin), .CLOCK_FAIL(fail), .FEEDBACK_SOURCE(fb),
		.ZERO_DELAY_RCV(zd), .REFERENCE_A_RCV(ra), .REFERENCE_B_RCV(rb),
		.OSCILLATOR_INPUT_FB_EN(oen), .REFERENCE_B_RDIV(rdiv), .VCTRL_FORCE_MID(fmid),
		.VCTRL_TRACK_PUMP(trk), .REF_MODE(mode), .REF_USE_B(useb));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	// settle past the edge so registered outputs have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	// strobe is dropped one edge later, so back-to-back calls never collide
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		we <= 1;
		addr <= a;
		wd <= v;
		@(posedge clk);
		we <= 0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		settle(1);
		chk(rdata, v);
	endtask : rd
	function automatic logic [1:0] fb_exp(input logic [7:0] v);
		return v[4] ? 2'h0 : (v[5] ? 2'h2 : 2'h1);
	endfunction : fb_exp
	// hang guard, well above the roughly 560 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		d = $urandom(51080);
		repeat (16) @(posedge clk);
		rst <= 0;
		settle(1);
		chk(fb, 2'h1);
		chk(mode, 3'h0);
		rd(`ILRF_ADDR_MISC, 8'h00);
		// random receiver and feedback settings, reserved bits set too
		repeat (40) begin
			d = $urandom;
			e = $urandom;
			wr(`ILRF_ADDR_RCV_FB, d);
			wr(`ILRF_ADDR_RCV_CTL, e);
			settle(2);
			chk(fb, fb_exp(d));
			chk(oen, d[4]);
			// a powered-down zero delay receiver shows no mode bits
			chk({zd.enable, zd.differential}, {2{d[5:4] == 2'h0}} & {1'b1, d[2]});
			chk(zd.pin_select, d[5:4] == 2'h0 && !d[2] && d[3]);
			chk(ra, {1'b1, e[5], ~e[5] & d[0]});
			chk(rb, {1'b1, e[6], ~e[6] & d[1]});
			rd(`ILRF_ADDR_RCV_FB, d & 8'h3F);
		end
		// every mode code with the select pin both ways
		for (int m = 0; m < 16; m++) begin
			@(posedge clk);
			pin <= m[3];
			wr(`ILRF_ADDR_MISC, {3'h0, m[2:0], 2'h3});
			settle(5);
			chk(mode, m[2] ? {2'h2, m[3]} : m[2:0]);
			chk(useb, m[2] ? m[3] : m[1] == m[0]);
			rd(`ILRF_ADDR_MISC, {3'h0, m[2:0], 2'h0});
		end
		// reset again mid-run with a pin mode loaded: the field must return to 000
		settle(1);
		rst <= 1;
		settle(2);
		rst <= 0;
		settle(2);
		chk(mode, 3'h0);
		chk(useb, 1'b1);
		rd(`ILRF_ADDR_MISC, 8'h00);
		d = $urandom;
		e = $urandom;
		wr(`ILRF_ADDR_RDIV_A_LO, d);
		wr(`ILRF_ADDR_RDIV_A_HI, 8'hFF);
		wr(`ILRF_ADDR_RDIV_B_LO, e);
		wr(`ILRF_ADDR_RDIV_B_HI, 8'h02);
		rd(`ILRF_ADDR_RDIV_A_HI, 8'h03);
		// shared ratio written only as for equal reference rates
		for (int b = 0; b < 2; b++) begin
			wr(`ILRF_ADDR_MISC, {b[0], 7'h40});
			settle(2);
			chk(rdiv, b ? {2'h2, e} : {2'h3, d});
		end
		for (int f = 0; f < 4; f++) begin
			@(posedge clk);
			fail <= f[0];
			wr(`ILRF_ADDR_MISC, {1'b0, f[1], 6'h0});
			settle(5);
			chk({fmid, trk}, {f[0] & f[1], f[0] & ~f[1]});
		end
		wr(10'h01D, 8'hA5);
		rd(10'h01D, 8'h00);
		close_out();
	end
endmodule : ilrf_top_test
bind ilrf_top ilrf_props u_props (.REF_CLK(REF_CLK), .RST(RST), .REG_WE(REG_WE),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .FEEDBACK_SOURCE(FEEDBACK_SOURCE),
	.ZERO_DELAY_RCV(ZERO_DELAY_RCV), .REFERENCE_A_RCV(REFERENCE_A_RCV),
	.REFERENCE_B_RCV(REFERENCE_B_RCV), .OSCILLATOR_INPUT_FB_EN(OSCILLATOR_INPUT_FB_EN),
	.VCTRL_FORCE_MID(VCTRL_FORCE_MID), .VCTRL_TRACK_PUMP(VCTRL_TRACK_PUMP),
	.REF_MODE(REF_MODE), .REF_USE_B(REF_USE_B));
`default_nettype wire
